// ---- logic/tws_pkg.sv ----
// Shared constants and types for the two-wire serial channel.
// Assumes a single 250 MHz clock domain and word-aligned Avalon-MM byte addresses.
package tws_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_SHIFT = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_OWN_ADDR = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_TRIG = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_EN = 0;
  localparam int CTRL_I2C = 1;
  localparam int CTRL_WUP = 2;
  localparam int CTRL_ACK_EN = 3;
  localparam int CTRL_WAIT_EN = 4;

  localparam int TRIG_RELEASE = 0;
  localparam int TRIG_COMMAND = 1;
  localparam int TRIG_WAIT_REL = 2;

  localparam int ST_DONE = 0;
  localparam int ST_MATCH = 1;
  localparam int ST_START = 2;
  localparam int ST_STOP = 3;
  localparam int ST_BUSY = 4;
  localparam int ST_SEL = 5;
  localparam int ST_DIR = 6;
  localparam int ST_ACK = 7;
  localparam int ST_SCL = 8;
  localparam int ST_HOLD = 9;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] CNT_RST = 3'h0;
  localparam logic [7:0] SHIFT_RST = 8'h00;
  localparam logic [7:0] SHIFT_ALL_ONES = 8'hFF;
  localparam logic [7:0] OWN_ADDR_RST = 8'h00;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TWS_IDLE,
    TWS_SHIFT,
    TWS_ACK
  } tws_state_t;

  typedef struct packed {
    logic en;
    logic i2c;
    logic wakeup_select_bit;
    logic ack_en;
    logic wait_en;
  } tws_ctrl_t;

  typedef struct packed {
    logic lvl;
    logic rise;
    logic fall;
  } tws_line_t;

endpackage

// ---- logic/tws_sync.sv ----
// Two-flop synchroniser and edge finder for the clock and data lines.
// Assumes both lines arrive asynchronously to clk.
`timescale 1ns/1ps
module tws_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output tws_pkg::tws_line_t scl,
  output tws_pkg::tws_line_t sda
);

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
  } tws_sync_state_t;

  tws_sync_state_t q_reg;
  tws_sync_state_t q_next;

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  // Idle bus is high, so reset to high avoids a false edge at release
  always_comb begin
    q_next = q_reg;
    q_next.s1 = {scl_in, sda_in};
    q_next.s2 = q_reg.s1;
    q_next.s3 = q_reg.s2;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q_reg <= '1;
    end else begin
      q_reg <= q_next;
    end
  end

  // Edges only from stages two and three
  assign scl.lvl = q_reg.s2[1];
  assign scl.rise = q_reg.s2[1] & ~q_reg.s3[1];
  assign scl.fall = ~q_reg.s2[1] & q_reg.s3[1];
  assign sda.lvl = q_reg.s2[0];
  assign sda.rise = q_reg.s2[0] & ~q_reg.s3[0];
  assign sda.fall = ~q_reg.s2[0] & q_reg.s3[0];

endmodule

// ---- logic/tws_channel.sv ----
// Two-wire serial / single-master bus slave channel with Avalon-MM registers.
// Assumes open-drain lines with external pull-ups; the partner supplies the clock.
`timescale 1ns/1ps
module tws_channel (
  input wire logic clk,
  input wire logic rst,
  input wire logic [tws_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic done_flag
);

  typedef struct packed {
    tws_pkg::tws_state_t st;
    tws_pkg::tws_ctrl_t ctrl;
    logic [2:0] cnt;
    logic [7:0] shift;
    logic [7:0] own_addr;
    logic so_latch;
    logic ack_plan;
    logic ack_drive;
    logic ack_rose;
    logic addr_phase;
    logic selected;
    logic dir;
    logic ack_seen;
    logic hold;
    logic done;
    logic match;
    logic start_seen;
    logic stop_seen;
    logic waitreq;
    logic [31:0] rdata;
    logic scl_oe;
    logic sda_oe;
  } tws_chan_state_t;

  tws_chan_state_t q_reg;
  tws_chan_state_t q_next;
  tws_pkg::tws_line_t scl;
  tws_pkg::tws_line_t sda;

  // ----------------------------------------------------------------
  // Line synchroniser
  // ----------------------------------------------------------------
  tws_sync u_sync (
    .clk(clk),
    .rst(rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl(scl),
    .sda(sda)
  );

  logic start_cond;
  logic stop_cond;
  logic acc;
  logic wr;
  logic [7:0] shifted;
  logic addr_hit;

  // Conditions need the clock high on both sampled stages
  assign start_cond = sda.fall & scl.lvl & ~scl.rise;
  assign stop_cond = sda.rise & scl.lvl & ~scl.rise;
  // A request is taken in the cycle waitrequest is low
  assign acc = (avs_read | avs_write) & ~q_reg.waitreq;
  assign wr = acc & avs_write & avs_byteenable[0];
  assign shifted = {q_reg.shift[6:0], sda.lvl};
  assign addr_hit = shifted[7:1] == q_reg.own_addr[7:1];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    q_next = q_reg;

    // Bus slave: one wait cycle, then answer; write commits on the answer edge
    if ((avs_read | avs_write) & q_reg.waitreq) begin
      q_next.waitreq = 1'b0;
    end
    // Only reads refresh the data; a write leaves the last answer standing
    if (avs_read & q_reg.waitreq) begin
      q_next.rdata = tws_pkg::RDATA_ZERO;
      unique case (avs_address)
        tws_pkg::OFS_CTRL: begin
          q_next.rdata[tws_pkg::CTRL_EN] = q_reg.ctrl.en;
          q_next.rdata[tws_pkg::CTRL_I2C] = q_reg.ctrl.i2c;
          q_next.rdata[tws_pkg::CTRL_WUP] = q_reg.ctrl.wakeup_select_bit;
          q_next.rdata[tws_pkg::CTRL_ACK_EN] = q_reg.ctrl.ack_en;
          q_next.rdata[tws_pkg::CTRL_WAIT_EN] = q_reg.ctrl.wait_en;
        end
        tws_pkg::OFS_SHIFT: begin
          q_next.rdata[tws_pkg::BYTE_W-1:0] = q_reg.shift;
        end
        tws_pkg::OFS_OWN_ADDR: begin
          q_next.rdata[tws_pkg::BYTE_W-1:0] = q_reg.own_addr;
        end
        tws_pkg::OFS_STATUS: begin
          q_next.rdata[tws_pkg::ST_DONE] = q_reg.done;
          q_next.rdata[tws_pkg::ST_MATCH] = q_reg.match;
          q_next.rdata[tws_pkg::ST_START] = q_reg.start_seen;
          q_next.rdata[tws_pkg::ST_STOP] = q_reg.stop_seen;
          q_next.rdata[tws_pkg::ST_BUSY] = q_reg.st != tws_pkg::TWS_IDLE;
          q_next.rdata[tws_pkg::ST_SEL] = q_reg.selected;
          q_next.rdata[tws_pkg::ST_DIR] = q_reg.dir;
          q_next.rdata[tws_pkg::ST_ACK] = q_reg.ack_seen;
          q_next.rdata[tws_pkg::ST_SCL] = q_reg.ctrl.en & scl.lvl;
          q_next.rdata[tws_pkg::ST_HOLD] = q_reg.hold;
        end
        default: begin
          q_next.rdata = tws_pkg::RDATA_ZERO;
        end
      endcase
    end
    if (acc) begin
      q_next.waitreq = 1'b1;
    end

    if (wr) begin
      unique case (avs_address)
        tws_pkg::OFS_CTRL: begin
          q_next.ctrl.en = avs_writedata[tws_pkg::CTRL_EN];
          q_next.ctrl.i2c = avs_writedata[tws_pkg::CTRL_I2C];
          q_next.ctrl.wakeup_select_bit = avs_writedata[tws_pkg::CTRL_WUP];
          q_next.ctrl.ack_en = avs_writedata[tws_pkg::CTRL_ACK_EN];
          q_next.ctrl.wait_en = avs_writedata[tws_pkg::CTRL_WAIT_EN];
        end
        tws_pkg::OFS_SHIFT: begin
          q_next.shift = avs_writedata[tws_pkg::BYTE_W-1:0];
          // Without the enable the byte is only stored, never sent later
          if (q_reg.ctrl.en && q_reg.st == tws_pkg::TWS_IDLE && (scl.lvl || q_reg.hold)) begin
            q_next.st = tws_pkg::TWS_SHIFT;
            q_next.cnt = tws_pkg::CNT_RST;
            q_next.so_latch = avs_writedata[tws_pkg::BYTE_W-1];
            // A shift write also ends our clock hold
            q_next.hold = 1'b0;
          end
        end
        tws_pkg::OFS_OWN_ADDR: begin
          q_next.own_addr = avs_writedata[tws_pkg::BYTE_W-1:0];
        end
        tws_pkg::OFS_TRIG: begin
          // Triggers are pulses: nothing is stored, so they read back as zero
          if (q_reg.ctrl.en && avs_writedata[tws_pkg::TRIG_RELEASE]) begin
            q_next.so_latch = 1'b1;
          end
          if (q_reg.ctrl.en && avs_writedata[tws_pkg::TRIG_COMMAND]) begin
            q_next.so_latch = 1'b0;
          end
          if (avs_writedata[tws_pkg::TRIG_WAIT_REL]) begin
            q_next.hold = 1'b0;
          end
        end
        tws_pkg::OFS_STATUS: begin
          // Write one to clear; events below override in the same cycle
          if (avs_writedata[tws_pkg::ST_DONE]) begin
            q_next.done = 1'b0;
          end
          if (avs_writedata[tws_pkg::ST_START]) begin
            q_next.start_seen = 1'b0;
          end
          if (avs_writedata[tws_pkg::ST_STOP]) begin
            q_next.stop_seen = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // Shift engine
    unique case (q_reg.st)
      tws_pkg::TWS_IDLE: begin
      end
      tws_pkg::TWS_SHIFT: begin
        if (scl.rise) begin
          q_next.shift = shifted;
          q_next.cnt = q_reg.cnt + 3'h1;
          if (q_reg.cnt == tws_pkg::LAST_BIT) begin
            q_next.ack_rose = 1'b0;
            q_next.ack_plan = 1'b0;
            q_next.st = q_reg.ctrl.i2c ? tws_pkg::TWS_ACK : tws_pkg::TWS_IDLE;
            if (q_reg.addr_phase) begin
              q_next.addr_phase = 1'b0;
              q_next.selected = addr_hit;
              q_next.dir = shifted[0];
              q_next.ack_plan = addr_hit;
              if (addr_hit || !q_reg.ctrl.wakeup_select_bit) begin
                q_next.done = 1'b1;
              end
            end else begin
              // Receiving a data byte: acknowledge only when asked to
              q_next.ack_plan = q_reg.ctrl.ack_en & ~q_reg.dir & q_reg.selected;
              if (!(q_reg.ctrl.i2c && q_reg.ctrl.wakeup_select_bit)) begin
                q_next.done = 1'b1;
              end
            end
          end
        end else if (scl.fall && q_reg.cnt != tws_pkg::CNT_RST) begin
          // Top bit left at the shift write; later bits go out on falls
          q_next.so_latch = q_reg.shift[tws_pkg::BYTE_W-1];
        end
      end
      tws_pkg::TWS_ACK: begin
        if (scl.fall && !q_reg.ack_rose) begin
          // Release data for the ninth pulse so the receiver can pull low
          q_next.so_latch = 1'b1;
          q_next.ack_drive = q_reg.ack_plan;
        end else if (scl.rise) begin
          q_next.ack_rose = 1'b1;
          q_next.ack_seen = ~sda.lvl;
        end else if (scl.fall) begin
          q_next.ack_drive = 1'b0;
          q_next.st = tws_pkg::TWS_IDLE;
          // Clock held low after the byte until software is ready
          q_next.hold = q_reg.ctrl.wait_en & q_reg.selected;
        end
      end
      default: begin
        q_next.st = tws_pkg::TWS_IDLE;
      end
    endcase

    // Bus conditions win over the engine
    if (q_reg.ctrl.en && q_reg.ctrl.i2c && start_cond) begin
      // A start mid-byte drops the partial byte
      q_next.start_seen = 1'b1;
      q_next.addr_phase = 1'b1;
      q_next.selected = 1'b0;
      q_next.st = tws_pkg::TWS_SHIFT;
      q_next.cnt = tws_pkg::CNT_RST;
      q_next.shift = tws_pkg::SHIFT_ALL_ONES;
      q_next.so_latch = 1'b1;
      q_next.ack_drive = 1'b0;
      q_next.hold = 1'b0;
    end
    if (q_reg.ctrl.en && q_reg.ctrl.i2c && stop_cond) begin
      q_next.stop_seen = 1'b1;
      q_next.selected = 1'b0;
      q_next.addr_phase = 1'b0;
      q_next.st = tws_pkg::TWS_IDLE;
      q_next.so_latch = 1'b1;
      q_next.ack_drive = 1'b0;
      q_next.hold = 1'b0;
    end

    // Comparator lags the shift register by one cycle
    // All eight bits compared, unlike the seven of the bus address
    q_next.match = q_reg.ctrl.en & (q_reg.own_addr == q_reg.shift);

    // Disabling the channel stops everything and releases both lines
    // Triggers are never stored, so nothing of theirs needs clearing
    if (!q_reg.ctrl.en) begin
      q_next.st = tws_pkg::TWS_IDLE;
      q_next.so_latch = 1'b1;
      q_next.ack_drive = 1'b0;
      q_next.hold = 1'b0;
      q_next.selected = 1'b0;
      q_next.addr_phase = 1'b0;
      q_next.match = 1'b0;
    end

    q_next.sda_oe = q_next.ctrl.en & (~q_next.so_latch | q_next.ack_drive);
    q_next.scl_oe = q_next.ctrl.en & q_next.hold;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      q_reg.st <= tws_pkg::TWS_IDLE;
      q_reg.ctrl <= '0;
      q_reg.cnt <= tws_pkg::CNT_RST;
      q_reg.shift <= tws_pkg::SHIFT_RST;
      q_reg.own_addr <= tws_pkg::OWN_ADDR_RST;
      q_reg.so_latch <= 1'b1;
      q_reg.ack_plan <= 1'b0;
      q_reg.ack_drive <= 1'b0;
      q_reg.ack_rose <= 1'b0;
      q_reg.addr_phase <= 1'b0;
      q_reg.selected <= 1'b0;
      q_reg.dir <= 1'b0;
      q_reg.ack_seen <= 1'b0;
      q_reg.hold <= 1'b0;
      q_reg.done <= 1'b0;
      q_reg.match <= 1'b0;
      q_reg.start_seen <= 1'b0;
      q_reg.stop_seen <= 1'b0;
      q_reg.waitreq <= 1'b1;
      q_reg.rdata <= tws_pkg::RDATA_ZERO;
      q_reg.scl_oe <= 1'b0;
      q_reg.sda_oe <= 1'b0;
    end else begin
      q_reg <= q_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Open-drain pins only ever drive low
  // The external pull-ups make every high level
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = q_reg.scl_oe;
  assign sda_oe = q_reg.sda_oe;
  assign avs_readdata = q_reg.rdata;
  assign avs_waitrequest = q_reg.waitreq;
  assign done_flag = q_reg.done;

endmodule

// ---- testbench/tws_channel_asserts.sv ----
// Checker for the channel's bus answers, open-drain pins and flags.
// Assumes it is bound to tws_channel and sees only that module's ports.
`timescale 1ns/1ps
module tws_channel_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic [tws_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic done_flag
);
  wire logic rel_wr = avs_write && !avs_waitrequest && avs_byteenable[0] &&
    avs_address == tws_pkg::OFS_TRIG && avs_writedata[0] && !avs_writedata[1];

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  AST_WAIT_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered in the next cycle");
  AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_RDATA_HOLD: assert property ($changed(avs_readdata) |-> avs_read && !avs_waitrequest)
    else $error("read data moved outside a read answer");
  AST_OPEN_DRAIN: assert property (!scl_out && !sda_out)
    else $error("open-drain line driven high");
  AST_RELEASE_TRIG: assert property (rel_wr |-> ##[1:3] !sda_oe)
    else $error("release trigger left the data line pulled");
  AST_CLK_HOLD: assert property ($rose(scl_oe) |-> !scl_in)
    else $error("clock hold began in a high phase");
  AST_HOLD_END: assert property ($fell(scl_oe) |->
    $past(avs_write, 1) || $past(avs_write, 2) || $past(avs_write, 3))
    else $error("clock hold ended without software");
  AST_DONE_STICKY: assert property ($fell(done_flag) |->
    $past(avs_write, 1) || $past(avs_write, 2) || $past(avs_write, 3))
    else $error("done flag cleared without software");
endmodule

bind tws_channel tws_channel_asserts u_chk (.clk(clk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .scl_in(scl_in), .scl_out(scl_out),
  .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe), .done_flag(done_flag));

// ---- testbench/tws_bus_master.sv ----
// Bus master model pulling the open-drain clock and data lines.
// Assumes the bench resolves each line with a pull-up and feeds it back.
`timescale 1ns/1ps
module tws_bus_master (
  input wire logic clk,
  input wire logic scl_line,
  input wire logic sda_line,
  output logic scl_pull,
  output logic sda_pull
);
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Release clock; a stretching slave delays the high phase
  task automatic rise();
    scl_pull <= 1'b0;
    do tick(1); while (!scl_line);
    tick(3);
  endtask

  task automatic grab();
    scl_pull <= 1'b1;
    tick(4);
  endtask

  task automatic start();
    sda_pull <= 1'b1;
    tick(4);
    grab();
  endtask

  // Data changes only in the low phase, two cycles clear of edges
  task automatic xfer(input logic [7:0] tx, input logic mack, input int n,
                      output logic [7:0] rx, output logic ack);
    for (int i = 0; i < n; i++) begin
      tick(2);
      sda_pull <= (i < 8) ? !tx[7-i] : mack;
      tick(2);
      rise();
      if (i < 8) rx[7-i] = sda_line;
      else ack = sda_line;
      scl_pull <= 1'b1;
    end
    tick(2);
    sda_pull <= 1'b0;
    tick(1);
  endtask

  task automatic stop();
    sda_pull <= 1'b1;
    tick(2);
    rise();
    sda_pull <= 1'b0;
    tick(4);
  endtask
endmodule

// ---- testbench/test_tws_channel.sv ----
// Self-checking bench: register bus master plus a bus master model.
// Assumes pulled-up lines: a line is low while any party pulls it.
`timescale 1ns/1ps
module test_tws_channel;
  logic clk, rst, avs_read, avs_write, avs_waitrequest, scl_in, sda_in;
  logic scl_out, scl_oe, sda_out, sda_oe, done_flag, m_scl, m_sda, ack;
  logic [4:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [7:0] tx, oth, rx;
  logic [6:0] aa;
  int seed, error_cnt, num_checks, cyc;
  localparam logic [4:0] CT = tws_pkg::OFS_CTRL;
  localparam logic [4:0] SH = tws_pkg::OFS_SHIFT;
  localparam logic [4:0] OA = tws_pkg::OFS_OWN_ADDR;
  localparam logic [4:0] TG = tws_pkg::OFS_TRIG;
  localparam logic [4:0] ST = tws_pkg::OFS_STATUS;
  localparam logic [31:0] SEL = 32'h1 << tws_pkg::ST_SEL;
  localparam logic [31:0] DIR = 32'h1 << tws_pkg::ST_DIR;
  localparam logic [31:0] MAT = 32'h1 << tws_pkg::ST_MATCH;
  localparam logic [31:0] HLD = 32'h1 << tws_pkg::ST_HOLD;
  localparam logic [31:0] SS = 32'hC;

  // Small phase offset keeps the line edges off the clock edges
  assign #1 scl_in = !(scl_oe || m_scl);
  assign #1 sda_in = !(sda_oe || m_sda);
  always #2 clk = ~clk;

  tws_channel u_dut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .scl_in(scl_in), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .done_flag(done_flag));
  tws_bus_master u_mst (.clk(clk), .scl_line(scl_in), .sda_line(sda_in), .scl_pull(m_scl), .sda_pull(m_sda));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] on_line(input logic [7:0] a, input logic [7:0] b);
    return {24'h0, a & b};
  endfunction

  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk); while (avs_waitrequest);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic rchk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(q & m, e);
  endtask

  task automatic results();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'hFCD2D697;
    clk = 1'b0;
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    rchk(CT, 32'hFFFF_FFFF, 32'h0);
    rchk(ST, 32'h3FF, 32'h0);
    wr(5'h14, 32'hFF);
    rchk(5'h14, 32'hFFFF_FFFF, 32'h0);
    avs_byteenable <= 4'hE;
    wr(OA, 32'h55);
    avs_byteenable <= 4'hF;
    rchk(OA, 32'hFF, 32'h0);
    wr(SH, 32'h00);
    wr(CT, 32'h01);
    rchk(ST, 32'h1 << tws_pkg::ST_BUSY, 32'h0);
    check(32'(sda_oe), 32'h0);
    wr(TG, 32'h2);
    repeat (2) @(posedge clk);
    check(32'(sda_oe), 32'h1);
    rchk(TG, 32'hFFFF_FFFF, 32'h0);
    wr(TG, 32'h1);
    repeat (2) @(posedge clk);
    check(32'(sda_oe), 32'h0);
    // First pass clean, later ones with a contending far side
    for (int i = 0; i < 6; i++) begin
      tx = 8'($random(seed));
      oth = (i == 0) ? 8'hFF : 8'($random(seed));
      wr(ST, 32'h1);
      wr(SH, {24'h0, tx});
      u_mst.grab();
      u_mst.xfer(oth, 1'b0, 8, rx, ack);
      u_mst.rise();
      check(32'(rx), on_line(tx, oth));
      check(32'(done_flag), 32'h1);
      rchk(SH, 32'hFF, on_line(tx, oth));
      wr(OA, {24'h0, tx});
      rchk(ST, MAT, (on_line(tx, oth) == {24'h0, tx}) ? MAT : 32'h0);
    end
    wr(ST, 32'h1);
    check(32'(done_flag), 32'h0);
    wr(TG, 32'h1);
    aa = 7'($random(seed));
    wr(OA, {24'h0, aa, 1'b0});
    wr(CT, 32'h1F);
    wr(ST, 32'hD);
    u_mst.start();
    u_mst.xfer({~aa[6], aa[5:0], 1'b0}, 1'b0, 9, rx, ack);
    check(32'(ack), 32'h1);
    check(32'(done_flag), 32'h0);
    u_mst.stop();
    rchk(ST, SS | SEL, SS);
    wr(ST, 32'hD);
    u_mst.start();
    u_mst.xfer({aa, 1'b0}, 1'b0, 9, rx, ack);
    check(32'(ack), 32'h0);
    check(32'(done_flag), 32'h1);
    repeat (4) @(posedge clk);
    rchk(ST, SEL | DIR | HLD, SEL | HLD);
    check(32'(scl_oe), 32'h1);
    wr(ST, 32'h1);
    tx = 8'($random(seed));
    wr(SH, 32'hFF);
    u_mst.xfer(tx, 1'b0, 9, rx, ack);
    check(32'(ack), 32'h0);
    check(32'(done_flag), 32'h0);
    rchk(SH, 32'hFF, {24'h0, tx});
    repeat (4) @(posedge clk);
    wr(TG, 32'h4);
    u_mst.stop();
    // Slave transmits; the master withholds the last acknowledge
    wr(CT, 32'h1B);
    wr(ST, 32'hD);
    u_mst.start();
    u_mst.xfer({aa, 1'b1}, 1'b0, 9, rx, ack);
    repeat (4) @(posedge clk);
    rchk(ST, SEL | DIR, SEL | DIR);
    tx = 8'($random(seed));
    wr(ST, 32'h1);
    wr(SH, {24'h0, tx});
    u_mst.xfer(8'hFF, 1'b0, 9, rx, ack);
    check(32'(ack), 32'h1);
    check(32'(rx), {24'h0, tx});
    check(32'(done_flag), 32'h1);
    repeat (4) @(posedge clk);
    wr(TG, 32'h4);
    u_mst.stop();
    rchk(ST, SEL, 32'h0);
    results();
  end
endmodule
